/* File: logic/hsotm_pkg.sv */
// constants shared by the on-time measurement block
package hsotm_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [3:0] HSOTM_OFF_RESULT  = 4'h0;
  localparam logic [3:0] HSOTM_OFF_CONTROL = 4'h4;
  localparam logic [3:0] HSOTM_OFF_STATUS  = 4'h8;
  localparam logic [3:0] HSOTM_OFF_MASK    = 4'hC;
  // field positions
  localparam int HSOTM_DONE_BIT   = 7;
  localparam int HSOTM_COUNT_W    = 7;
  localparam int HSOTM_CTL_EN_BIT = 0;
  localparam int HSOTM_CTL_RUN_BIT = 1;
  localparam int HSOTM_ST_DONE_BIT = 0;
  localparam int HSOTM_ST_OVF_BIT  = 1;
  // reset values
  localparam logic [7:0] HSOTM_RESULT_RST = 8'h00;
  localparam logic [1:0] HSOTM_CTL_RST    = 2'h0;
  localparam logic [1:0] HSOTM_IRQ_RST    = 2'h0;
  localparam logic [31:0] HSOTM_UNMAPPED  = 32'h0000_0000;
  // measurement states
  typedef enum logic [3:0] {
    HSOTM_IDLE = 4'b0001,
    HSOTM_WAIT = 4'b0010,
    HSOTM_MEAS = 4'b0100,
    HSOTM_DONE = 4'b1000
  } hsotm_state_type;
endpackage : hsotm_pkg

/* File: logic/hsotm_core.sv */
// high-side on-time measurement with avalon-mm register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module hsotm_core
  import hsotm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        high_side_drive,
  output logic             circuit_power_en,
  output logic             irq
);

  // pin synchroniser for the gate drive signal
  logic            drv_meta_ff;
  logic            drv_sync_ff;
  logic            drv_prev_ff;
  // registers
  logic [1:0]      ctl_ff;
  logic [HSOTM_COUNT_W-1:0] count_ff;
  logic            done_ff;
  logic [1:0]      sts_ff;
  logic [1:0]      mask_ff;
  logic [31:0]     rdata_ff;
  logic            ack_ff;
  hsotm_state_type state_ff;
  hsotm_state_type nxt_state;

  // address decode and strobes
  wire        acc      = (avs_read | avs_write) & ~ack_ff;
  wire        wr_hit   = avs_write & ack_ff & avs_byteenable[0]; // commit when wait ends
  wire        wr_ctl   = wr_hit & (avs_address == HSOTM_OFF_CONTROL);
  wire        wr_sts   = wr_hit & (avs_address == HSOTM_OFF_STATUS);
  wire        wr_mask  = wr_hit & (avs_address == HSOTM_OFF_MASK);
  wire        enable   = ctl_ff[HSOTM_CTL_EN_BIT];
  wire        run      = ctl_ff[HSOTM_CTL_RUN_BIT] & enable;
  wire        rise     = drv_sync_ff & ~drv_prev_ff;
  wire        fall     = ~drv_sync_ff & drv_prev_ff;
  wire        sat      = &count_ff;
  wire        ev_done  = (state_ff == HSOTM_MEAS) & fall;
  wire        ev_ovf   = (state_ff == HSOTM_MEAS) & drv_sync_ff & sat;
  wire [1:0]  ev_vec   = {ev_ovf, ev_done};
  wire [7:0]  result   = {done_ff, count_ff};
  wire [31:0] rd_mux   =
    (avs_address == HSOTM_OFF_RESULT)  ? {24'h000000, result} :
    (avs_address == HSOTM_OFF_CONTROL) ? {30'h0, ctl_ff} :
    (avs_address == HSOTM_OFF_STATUS)  ? {30'h0, sts_ff} :
    (avs_address == HSOTM_OFF_MASK)    ? {30'h0, mask_ff} : HSOTM_UNMAPPED;

  assign avs_waitrequest  = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata     = rdata_ff;
  assign circuit_power_en = enable;
  assign irq              = |(sts_ff & mask_ff);

  // two-flop synchroniser, then edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drv_meta_ff <= 1'b0;
      drv_sync_ff <= 1'b0;
      drv_prev_ff <= 1'b0;
    end else begin
      drv_meta_ff <= high_side_drive;
      drv_sync_ff <= drv_meta_ff;
      drv_prev_ff <= drv_sync_ff;
    end
  end

  // bus handshake: one wait cycle, data registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= HSOTM_UNMAPPED;
    end else begin
      ack_ff   <= acc;
      rdata_ff <= (acc & avs_read) ? rd_mux : rdata_ff;
    end
  end

  // control and mask registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_ff  <= HSOTM_CTL_RST;
      mask_ff <= HSOTM_IRQ_RST;
    end else begin
      if (wr_ctl) ctl_ff <= avs_writedata[1:0];
      if (wr_mask) mask_ff <= avs_writedata[1:0];
    end
  end

  // sticky status; a new event beats a write-one clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sts_ff <= HSOTM_IRQ_RST;
    end else begin
      sts_ff <= (sts_ff & ~(wr_sts ? avs_writedata[1:0] : 2'h0)) | ev_vec;
    end
  end

  // measurement sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HSOTM_IDLE: if (run) nxt_state = HSOTM_WAIT;
      HSOTM_WAIT: if (!run) nxt_state = HSOTM_IDLE;
                  else if (rise) nxt_state = HSOTM_MEAS;
      HSOTM_MEAS: if (!run) nxt_state = HSOTM_IDLE;
                  else if (fall) nxt_state = HSOTM_DONE;
      HSOTM_DONE: if (!run) nxt_state = HSOTM_IDLE;
      default:    nxt_state = HSOTM_IDLE;
    endcase
  end

  // counter and done flag, owned by hardware alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= HSOTM_IDLE;
      count_ff <= HSOTM_RESULT_RST[6:0];
      done_ff  <= HSOTM_RESULT_RST[HSOTM_DONE_BIT];
    end else begin
      state_ff <= nxt_state;
      if (state_ff == HSOTM_IDLE) count_ff <= '0;
      else if (state_ff == HSOTM_WAIT && rise) count_ff <= 7'h01;
      else if (state_ff == HSOTM_MEAS && drv_sync_ff && !sat)
        count_ff <= count_ff + 7'h01;
      done_ff <= (nxt_state == HSOTM_DONE);
    end
  end

  // done must follow the sequencer and clear when run drops
  property p_done_tracks;
    @(posedge clk) disable iff (!rst_n)
      ev_done & run |=> done_ff;
  endproperty
  a_done_tracks: assert property (p_done_tracks) else $error("done not set");

  property p_done_clears;
    @(posedge clk) disable iff (!rst_n)
      done_ff & ~run |=> ~done_ff;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("done stuck");

  property p_bit7;
    @(posedge clk) disable iff (!rst_n)
      acc & avs_read & (avs_address == HSOTM_OFF_RESULT) |=>
        avs_readdata[HSOTM_DONE_BIT] == $past(done_ff);
  endproperty
  a_bit7: assert property (p_bit7) else $error("done not in bit 7");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == HSOTM_DONE) & run |=> $stable(count_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while held");

  property p_step;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == HSOTM_MEAS) & drv_sync_ff & ~sat & run |=>
        count_ff == $past(count_ff) + 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");

  sequence s_start;
    run & (state_ff == HSOTM_IDLE);
  endsequence
  property p_start;
    @(posedge clk) disable iff (!rst_n)
      s_start |=> (state_ff == HSOTM_WAIT) | ~run;
  endproperty
  a_start: assert property (p_start) else $error("run did not start cycle");

  property p_power;
    @(posedge clk) disable iff (!rst_n)
      wr_ctl |=> circuit_power_en == $past(avs_writedata[HSOTM_CTL_EN_BIT]);
  endproperty
  a_power: assert property (p_power) else $error("power enable wrong");

  property p_measure;
    @(posedge clk) disable iff (!rst_n)
      (state_ff == HSOTM_WAIT) & rise & run |=> (state_ff == HSOTM_MEAS) && count_ff == 7'h01;
  endproperty
  a_measure: assert property (p_measure) else $error("on-time not captured");

  // overflow status is sticky once the drive stays high while the counter is saturated
  property p_ovf_set;
    @(posedge clk) disable iff (!rst_n)
      ev_ovf |=> sts_ff[HSOTM_ST_OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

  // a write of one clears the done event unless a new one arrives
  property p_w1c;
    @(posedge clk) disable iff (!rst_n)
      wr_sts & avs_writedata[HSOTM_ST_DONE_BIT] & ~ev_done |=> ~sts_ff[HSOTM_ST_DONE_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("done status not cleared");

  // every bus request waits exactly one cycle
  property p_one_wait;
    @(posedge clk) disable iff (!rst_n)
      avs_waitrequest |=> ~avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");

endmodule : hsotm_core
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the on-time measurement block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hsotm_pkg::*;
  logic        clk             = 1'b0;
  logic        rst_n           = 1'b0;
  logic [3:0]  avs_address     = 4'h0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [3:0]  avs_byteenable  = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        high_side_drive = 1'b0;
  logic        circuit_power_en;
  logic        irq;
  int          errors          = 0;
  int          checks_done     = 0;
  int          len;
  logic [31:0] exp_q[$];

  hsotm_core i_hsotm_core (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .high_side_drive(high_side_drive),
    .circuit_power_en(circuit_power_en), .irq(irq));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // one bus transfer, entered just after a rising edge, held until waitrequest low
  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (k >= 40) begin
      errors++;
      summarize();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : access

  // note the expected word, then read
  task automatic rd(input logic [3:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    access(1'b0, a, 32'h0);
  endtask : rd

  // sample a design output mid-cycle
  task automatic look(input logic seen_now, input logic want);
    @(negedge clk);
    check({31'h0, (seen_now ? circuit_power_en : irq)}, {31'h0, want});
    @(posedge clk);
  endtask : look

  // gate-drive pulse of n clocks, then settle
  task automatic pulse(input int n);
    high_side_drive <= 1'b1;
    repeat (n) @(posedge clk);
    high_side_drive <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse

  // bounded wait for the done interrupt
  task automatic wait_irq;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (irq !== 1'b1 && k < 300);
    if (k >= 300) begin
      errors++;
      summarize();
    end
    @(posedge clk);
  endtask : wait_irq

  // read results are compared in arrival order
  always @(posedge clk)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check(avs_readdata, exp_q.pop_front());

  // main sequence
  initial begin
    void'($urandom(32'hCFCA));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(HSOTM_OFF_RESULT, {24'h0, HSOTM_RESULT_RST});
    rd(HSOTM_OFF_STATUS, 32'h0);
    rd(4'h2, HSOTM_UNMAPPED);
    avs_byteenable <= 4'h0;
    access(1'b1, HSOTM_OFF_CONTROL, 32'h1);
    avs_byteenable <= 4'hF;
    look(1'b1, 1'b0);
    access(1'b1, HSOTM_OFF_CONTROL, 32'h2);
    pulse(10);
    rd(HSOTM_OFF_RESULT, 32'h0);
    access(1'b1, HSOTM_OFF_CONTROL, 32'h0);
    access(1'b1, HSOTM_OFF_MASK, 32'h1);
    rd(HSOTM_OFF_MASK, 32'h1);
    access(1'b1, HSOTM_OFF_CONTROL, 32'h1);
    look(1'b1, 1'b1);
    rd(HSOTM_OFF_RESULT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      access(1'b1, HSOTM_OFF_CONTROL, 32'h3);
      len = $urandom_range(100, 2);
      pulse(len);
      wait_irq();
      repeat (10) @(posedge clk);
      rd(HSOTM_OFF_RESULT, 32'h80 | len);
      access(1'b1, HSOTM_OFF_RESULT, 32'h0);
      pulse(5);
      rd(HSOTM_OFF_RESULT, 32'h80 | len);
      access(1'b1, HSOTM_OFF_STATUS, 32'h1);
      look(1'b0, 1'b0);
      access(1'b1, HSOTM_OFF_CONTROL, 32'h1);
      repeat (2) @(posedge clk);
      rd(HSOTM_OFF_RESULT, 32'h0);
    end
    access(1'b1, HSOTM_OFF_CONTROL, 32'h3);
    pulse(140);
    wait_irq();
    rd(HSOTM_OFF_RESULT, 32'hFF);
    rd(HSOTM_OFF_STATUS, 32'h3);
    access(1'b1, HSOTM_OFF_STATUS, 32'h3);
    look(1'b0, 1'b0);
    access(1'b1, HSOTM_OFF_CONTROL, 32'h0);
    look(1'b1, 1'b0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
